// >>> tsi_map.svh
/*
 * Constants of the temperature sensor command port: bus address, command
 * codes, checksum polynomial and conversion timing.
 * Assumes a 10 MHz system clock; included by bare name.
 */
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH

`define TSI_DEF_ADDR       7'h40
`define TSI_CMD_RESET      8'h1e
`define TSI_CMD_SERIAL     8'h0a
`define TSI_CMD_CONVERT    8'h46
`define TSI_CMD_READ       8'h00
`define TSI_CRC_POLY       8'h31
`define TSI_CRC_INIT       8'h00
`define TSI_FILL_BYTE      8'hff
`define TSI_CLK_PERIOD_NS  100
`define TSI_CONV_TIME_MS   12
`define TSI_CONV_CYC       ((`TSI_CONV_TIME_MS * 1000000) / `TSI_CLK_PERIOD_NS)

`endif

// >>> tsi_pkg.sv
/*
 * Types of the temperature sensor command port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tsi_pkg;

    typedef enum logic [2:0] {
        TSI_IDLE = 3'b000,
        TSI_RX   = 3'b001,
        TSI_HOLD = 3'b010,
        TSI_ACK  = 3'b011,
        TSI_TX   = 3'b100,
        TSI_MACK = 3'b101,
        TSI_LOAD = 3'b110
    } tsi_state_t;

endpackage

// >>> tsi_line_if.sv
/*
 * Interface carrying bus line events from the pin sampler to the
 * byte engine. Assumes both ends run on the one system clock.
 */
`timescale 1ns/100ps

interface tsi_line_if;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sda;

    modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
    modport snk (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// >>> tsi_line_det.sv
/*
 * Pin sampler: registers the clock and data lines and reports edges,
 * start and stop conditions as one-cycle pulses.
 * Assumes line inputs are already synchronous to clk_i.
 */
`timescale 1ns/100ps

module tsi_line_det
    import tsi_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    tsi_line_if.src   ev
);
    logic scl_q, scl_d;
    logic sda_q, sda_d;

    // Idle bus is high on both lines
    always_comb begin
        scl_d = scl_i;
        sda_d = sda_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_d;
            sda_q <= sda_d;
        end
    end

    // Data moving while clock is high frames a message
    assign ev.scl_rise = scl_i & ~scl_q;
    assign ev.scl_fall = ~scl_i & scl_q;
    assign ev.start    = scl_i & scl_q & sda_q & ~sda_i;
    assign ev.stop     = scl_i & scl_q & ~sda_q & sda_i;
    assign ev.sda      = sda_i;
endmodule

// >>> tsi_crc_step.sv
/*
 * One byte step of an MSB-first CRC-8, purely combinational.
 * Assumes the caller chains instances for multi-byte data.
 */
`timescale 1ns/100ps

`include "tsi_map.svh"

module tsi_crc_step
    import tsi_pkg::*;
#(
    parameter logic [7:0] POLY = `TSI_CRC_POLY
) (
    input  wire logic [7:0] crc_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] crc_o
);
    // Eight shift steps, feedback taken from the top bit
    always_comb begin
        logic [7:0] c;
        c = crc_i ^ data_i;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ({c[6:0], 1'b0} ^ POLY) : {c[6:0], 1'b0};
        end
        crc_o = c;
    end
endmodule

// >>> tsi_top.sv
/*
 * Bus command port of a digital temperature sensor: address match with
 * default and alternative address, command decode, conversion timer,
 * result and serial readout with checksum.
 * Assumes synchronous line inputs, an external converter sampled on
 * adc_data_i at conversion end, and nonvolatile values held steady.
 */
`timescale 1ns/100ps

`include "tsi_map.svh"

module tsi_top
    import tsi_pkg::*;
#(
    parameter int unsigned CONV_CYC = `TSI_CONV_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    input  wire logic [15:0] adc_data_i,
    input  wire logic [15:0] nvm_serial_i,
    input  wire logic [6:0]  nvm_alt_addr_i,
    input  wire logic        nvm_alt_vld_i,
    input  wire logic [6:0]  alt_addr_i,
    input  wire logic        tmp_alt_wr_i,
    input  wire logic        perm_alt_wr_i,
    output logic             conv_start_o,
    output logic             conv_busy_o,
    output logic             mem_crc_ok_o
);
    tsi_line_if ev ();

    tsi_line_det u_det (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .scl_i     (scl_i),
        .sda_i     (sda_i),
        .ev        (ev)
    );

    tsi_state_t  st_q,   st_d;
    logic [7:0]  sh_q,   sh_d;
    logic [2:0]  cnt_q,  cnt_d;
    logic        cmd_q,  cmd_d;   // Receiving the command byte
    logic        rd_q,   rd_d;
    logic [1:0]  idx_q,  idx_d;
    logic        oe_n_q, oe_n_d;
    logic        ser_q,  ser_d;   // Readout source is the serial number
    logic        busy_q, busy_d;
    logic [16:0] tmr_q,  tmr_d;
    logic [15:0] res_q,  res_d;
    logic        go_q,   go_d;
    logic        tvld_q, tvld_d;
    logic [6:0]  taddr_q, taddr_d;
    logic        pvld_q, pvld_d;
    logic [6:0]  paddr_q, paddr_d;
    logic        crok_q, crok_d;
    logic        init_q, init_d;

    logic [15:0] word;
    logic [7:0]  crc_mid, crc_fin, tx_byte;
    logic        match, do_reset, do_conv;

    // Readout word and its checksum over both data bytes
    assign word = ser_q ? nvm_serial_i : res_q;

    tsi_crc_step #(.POLY(`TSI_CRC_POLY)) u_crc_hi (
        .crc_i  (`TSI_CRC_INIT),
        .data_i (word[15:8]),
        .crc_o  (crc_mid)
    );

    tsi_crc_step #(.POLY(`TSI_CRC_POLY)) u_crc_lo (
        .crc_i  (crc_mid),
        .data_i (word[7:0]),
        .crc_o  (crc_fin)
    );

    // Byte order of a read
    always_comb begin
        unique case (idx_q)
            2'd0:    tx_byte = word[15:8];
            2'd1:    tx_byte = word[7:0];
            2'd2:    tx_byte = crc_fin;
            default: tx_byte = `TSI_FILL_BYTE;
        endcase
    end

    // The default, temporary or permanent address may select the device
    assign match = (sh_q[7:1] == `TSI_DEF_ADDR)
                 | (tvld_q & (sh_q[7:1] == taddr_q))
                 | (pvld_q & (sh_q[7:1] == paddr_q));

    // Command byte decode, acted on at its acknowledge
    assign do_reset = (st_q == TSI_HOLD) & cmd_q & ev.scl_fall
                    & (sh_q == `TSI_CMD_RESET);
    assign do_conv  = (st_q == TSI_HOLD) & cmd_q & ev.scl_fall
                    & (sh_q == `TSI_CMD_CONVERT);

    // Byte engine: bits in on clock rise, out on clock fall
    always_comb begin
        st_d   = st_q;
        sh_d   = sh_q;
        cnt_d  = cnt_q;
        cmd_d  = cmd_q;
        rd_d   = rd_q;
        idx_d  = idx_q;
        oe_n_d = oe_n_q;
        ser_d  = ser_q;
        if (ev.stop) begin
            st_d   = TSI_IDLE;
            oe_n_d = 1'b1;
        end else if (ev.start) begin
            // Repeated start allowed, begins a new address byte
            st_d   = TSI_RX;
            cnt_d  = 3'd0;
            cmd_d  = 1'b0;
            idx_d  = 2'd0;
            oe_n_d = 1'b1;
        end else begin
            unique case (st_q)
                TSI_IDLE: begin
                    oe_n_d = 1'b1;
                end
                TSI_RX: begin
                    if (ev.scl_rise) begin
                        sh_d  = {sh_q[6:0], ev.sda};
                        cnt_d = cnt_q + 3'd1;
                        if (cnt_q == 3'd7) begin
                            st_d = TSI_HOLD;
                        end
                    end
                end
                TSI_HOLD: begin
                    if (ev.scl_fall) begin
                        if (cmd_q) begin
                            // Every command byte is acknowledged
                            oe_n_d = 1'b0;
                            st_d   = TSI_ACK;
                            if (sh_q == `TSI_CMD_SERIAL) begin
                                ser_d = 1'b1;
                            end else if (sh_q == `TSI_CMD_READ) begin
                                ser_d = 1'b0;
                            end
                        end else if (match) begin
                            oe_n_d = 1'b0;
                            rd_d   = sh_q[0];
                            st_d   = TSI_ACK;
                        end else begin
                            st_d = TSI_IDLE;
                        end
                    end
                end
                TSI_ACK: begin
                    if (ev.scl_fall) begin
                        cnt_d = 3'd0;
                        if (rd_q && !cmd_q) begin
                            oe_n_d = tx_byte[7];
                            st_d   = TSI_TX;
                        end else if (!cmd_q) begin
                            oe_n_d = 1'b1;
                            cmd_d  = 1'b1;
                            st_d   = TSI_RX;
                        end else begin
                            // Two-byte command done; extra bytes ignored
                            oe_n_d = 1'b1;
                            st_d   = TSI_IDLE;
                        end
                    end
                end
                TSI_TX: begin
                    if (ev.scl_fall) begin
                        cnt_d = cnt_q + 3'd1;
                        if (cnt_q == 3'd7) begin
                            oe_n_d = 1'b1;
                            st_d   = TSI_MACK;
                        end else begin
                            oe_n_d = tx_byte[3'd6 - cnt_q];
                        end
                    end
                end
                TSI_MACK: begin
                    if (ev.scl_rise) begin
                        if (ev.sda) begin
                            st_d = TSI_IDLE;   // Not acknowledged, read ends
                        end else begin
                            idx_d = (idx_q == 2'd3) ? idx_q : idx_q + 2'd1;
                            st_d  = TSI_LOAD;
                        end
                    end
                end
                TSI_LOAD: begin
                    if (ev.scl_fall) begin
                        cnt_d  = 3'd0;
                        oe_n_d = tx_byte[7];
                        st_d   = TSI_TX;
                    end
                end
                default: begin
                    st_d   = TSI_IDLE;
                    oe_n_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q   <= TSI_IDLE;
            sh_q   <= 8'h00;
            cnt_q  <= 3'd0;
            cmd_q  <= 1'b0;
            rd_q   <= 1'b0;
            idx_q  <= 2'd0;
            oe_n_q <= 1'b1;
            ser_q  <= 1'b0;
        end else begin
            st_q   <= st_d;
            sh_q   <= sh_d;
            cnt_q  <= cnt_d;
            cmd_q  <= cmd_d;
            rd_q   <= rd_d;
            idx_q  <= idx_d;
            oe_n_q <= oe_n_d;
            ser_q  <= ser_d;
        end
    end

    // Conversion timer; the reset command overrides a start and aborts a run
    always_comb begin
        busy_d = busy_q;
        tmr_d  = tmr_q;
        res_d  = res_q;
        go_d   = 1'b0;
        if (do_reset) begin
            busy_d = 1'b0;
            tmr_d  = 17'd0;
            res_d  = 16'h0000;
        end else if (do_conv) begin
            busy_d = 1'b1;
            go_d   = 1'b1;
            tmr_d  = 17'(CONV_CYC - 1);
        end else if (busy_q) begin
            if (tmr_q == 17'd0) begin
                busy_d = 1'b0;
                // Raw code; temperature is -40 + code * 165 / 65535
                res_d  = adc_data_i;
            end else begin
                tmr_d = tmr_q - 17'd1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy_q <= 1'b0;
            tmr_q  <= 17'd0;
            res_q  <= 16'h0000;
            go_q   <= 1'b0;
        end else begin
            busy_q <= busy_d;
            tmr_q  <= tmr_d;
            res_q  <= res_d;
            go_q   <= go_d;
        end
    end

    // Alternative addresses; production value is caught after reset release
    always_comb begin
        init_d  = 1'b1;
        tvld_d  = tvld_q;
        taddr_d = taddr_q;
        pvld_d  = pvld_q;
        paddr_d = paddr_q;
        crok_d  = crok_q;
        if (!init_q) begin
            pvld_d  = nvm_alt_vld_i;
            paddr_d = nvm_alt_addr_i;
            crok_d  = 1'b1;   // Production-stored address keeps checksum valid
        end else if (perm_alt_wr_i && !pvld_q) begin
            // One-time write only; a later attempt is ignored
            pvld_d  = 1'b1;
            paddr_d = alt_addr_i;
            crok_d  = 1'b0;
        end
        // A write landing together with the reset command wins
        if (tmp_alt_wr_i) begin
            tvld_d  = 1'b1;
            taddr_d = alt_addr_i;
        end else if (do_reset) begin
            tvld_d = 1'b0;
        end
    end

    // Temporary address lost on power restart through sys_rst_i
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            init_q  <= 1'b0;
            tvld_q  <= 1'b0;
            taddr_q <= 7'h00;
            pvld_q  <= 1'b0;
            paddr_q <= 7'h00;
            crok_q  <= 1'b1;
        end else begin
            init_q  <= init_d;
            tvld_q  <= tvld_d;
            taddr_q <= taddr_d;
            pvld_q  <= pvld_d;
            paddr_q <= paddr_d;
            crok_q  <= crok_d;
        end
    end

    // Open-drain data: only ever pulls low
    assign sda_o        = 1'b0;
    assign sda_oe_n_o   = oe_n_q;
    assign conv_start_o = go_q;
    assign conv_busy_o  = busy_q;
    assign mem_crc_ok_o = crok_q;
endmodule

// >>> tsi_top_properties.sv
/*
 * Checker for the temperature sensor command port: open-drain drive,
 * reset values, bus timing of the data enable, conversion and checksum flag.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/100ps

module tsi_chk #(
    parameter int unsigned CONV_CYC = 20
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic scl_i,
    input  wire logic perm_alt_wr_i,
    input  wire logic sda_o,
    input  wire logic sda_oe_n_o,
    input  wire logic conv_start_o,
    input  wire logic conv_busy_o,
    input  wire logic mem_crc_ok_o
);
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    // Length of the current busy stretch, aborts make it shorter
    always_comb begin
        busy_cnt_d = conv_busy_o ? busy_cnt_q + 32'h1 : 32'h0;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // Enable may only move just after a clock fall on the bus
    sequence s_fall_seen;
        !scl_i && ($past(scl_i, 2) || $past(scl_i, 3));
    endsequence

    sequence s_busy_soon;
        ##[0:1] conv_busy_o;
    endsequence

    property p_od_low;     !sda_oe_n_o |-> sda_o == 1'b0; endproperty
    property p_rst_vals;
        $fell(sys_rst_i) |-> sda_oe_n_o && !conv_start_o && !conv_busy_o && mem_crc_ok_o;
    endproperty
    property p_oe_on_fall; $changed(sda_oe_n_o) |-> s_fall_seen; endproperty
    property p_oe_hold;    scl_i && $past(scl_i) |-> $stable(sda_oe_n_o); endproperty
    property p_start_pulse; conv_start_o |=> !conv_start_o; endproperty
    property p_start_busy; conv_start_o |-> s_busy_soon; endproperty
    property p_busy_cause; $rose(conv_busy_o) |-> conv_start_o || $past(conv_start_o); endproperty
    property p_busy_len;   busy_cnt_q <= CONV_CYC + 1; endproperty
    property p_crc_cause;
        $fell(mem_crc_ok_o) |-> $past(perm_alt_wr_i) || $past(perm_alt_wr_i, 2);
    endproperty
    property p_crc_sticky; !mem_crc_ok_o |=> !mem_crc_ok_o; endproperty

    a_od_low:      assert property (p_od_low) else $error("data driven high");
    a_rst_vals:    assert property (p_rst_vals) else $error("bad reset values");
    a_oe_on_fall:  assert property (p_oe_on_fall) else $error("enable moved off fall");
    a_oe_hold:     assert property (p_oe_hold) else $error("enable moved in high phase");
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    a_start_busy:  assert property (p_start_busy) else $error("start without busy");
    a_busy_cause:  assert property (p_busy_cause) else $error("busy without start");
    a_busy_len:    assert property (p_busy_len) else $error("conversion too long");
    a_crc_cause:   assert property (p_crc_cause) else $error("checksum flag fell alone");
    a_crc_sticky:  assert property (p_crc_sticky) else $error("checksum flag recovered");
endmodule

bind tsi_top tsi_chk #(.CONV_CYC(CONV_CYC)) u_chk (
    .clk_i        (clk_i),
    .sys_rst_i    (sys_rst_i),
    .scl_i        (scl_i),
    .perm_alt_wr_i(perm_alt_wr_i),
    .sda_o        (sda_o),
    .sda_oe_n_o   (sda_oe_n_o),
    .conv_start_o (conv_start_o),
    .conv_busy_o  (conv_busy_o),
    .mem_crc_ok_o (mem_crc_ok_o)
);

// >>> tsi_mst_model.sv
/*
 * Bus master model: start, stop and nine-bit byte transfers.
 * Assumes a pulled-up data line resolved by the bench; 1 on sda_o releases.
 */
`timescale 1ns/100ps

module tsi_mst_model #(
    parameter int PH = 4
) (
    input  wire logic clk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_o
);
    // Idle bus: both lines released
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // Changes land just after an edge, never on it
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask

    task automatic start_cond();
        sda_o = 1'b1;
        scl_o = 1'b1;
        wait_cyc(PH);
        sda_o = 1'b0;
        wait_cyc(PH);
        scl_o = 1'b0;
        wait_cyc(2);
    endtask

    task automatic stop_cond();
        sda_o = 1'b0;
        wait_cyc(PH);
        scl_o = 1'b1;
        wait_cyc(PH);
        sda_o = 1'b1;
        wait_cyc(PH);
    endtask

    // Data set in low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        wait_cyc(PH);
        scl_o = 1'b1;
        wait_cyc(PH / 2);
        r = sda_i;
        wait_cyc(PH / 2);
        scl_o = 1'b0;
        wait_cyc(2);
    endtask

    // Frees a held data line: nine clock pulses, data released
    task automatic clk_flush();
        sda_o = 1'b1;
        repeat (9) begin
            scl_o = 1'b0;
            wait_cyc(PH);
            scl_o = 1'b1;
            wait_cyc(PH);
        end
    endtask

    // r[8:1] is the byte seen, r[0] the ninth bit
    task automatic byte_io(input logic [7:0] w, input logic m, output logic [8:0] r);
        for (int i = 7; i >= 0; i--) begin
            bit_io(w[i], r[i + 1]);
        end
        bit_io(m, r[0]);
    endtask
endmodule

// >>> testbench.sv
/*
 * Self-checking bench of the temperature sensor command port.
 * Assumes the master model and the bound checker; short conversion count.
 */
`timescale 1ns/100ps

`include "tsi_map.svh"

module testbench;
    import tsi_pkg::*;

    localparam int unsigned CONV = 400;
    localparam logic [15:0] SERIAL = 16'h5a3c;

    logic        clk_i;
    logic        sys_rst_i;
    logic        tmp_alt_wr_i;
    logic        perm_alt_wr_i;
    logic [15:0] adc_data_i;
    logic [6:0]  alt_addr_i;
    logic [6:0]  nvm_alt_addr;
    logic        nvm_alt_vld;
    logic        scl;
    logic        m_sda;
    logic        sda_o;
    logic        sda_oe_n_o;
    logic        conv_start_o;
    logic        conv_busy_o;
    logic        mem_crc_ok_o;
    int          err_total;
    int          checked;
    int          cyc;
    int          starts;
    int          busy_cyc;
    wire logic   sda_line = m_sda & (sda_oe_n_o | sda_o);  // Pulled-up open drain

    tsi_top #(.CONV_CYC(CONV)) u_dut (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .adc_data_i(adc_data_i),
        .nvm_serial_i(SERIAL), .nvm_alt_addr_i(nvm_alt_addr), .nvm_alt_vld_i(nvm_alt_vld),
        .alt_addr_i(alt_addr_i), .tmp_alt_wr_i(tmp_alt_wr_i),
        .perm_alt_wr_i(perm_alt_wr_i), .conv_start_o(conv_start_o),
        .conv_busy_o(conv_busy_o), .mem_crc_ok_o(mem_crc_ok_o)
    );

    tsi_mst_model u_mst (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_o(m_sda));

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Cycle budget, start pulses and busy cycles
    always @(posedge clk_i) begin
        cyc++;
        starts += (conv_start_o === 1'b1);
        busy_cyc += (conv_busy_o === 1'b1);
        if (cyc == 30000) begin
            err_total++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checked=%0d err_total=%0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // MSB-first CRC-8, zero start value
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `TSI_CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    // Address byte with write direction then one code byte
    task automatic cmd(input logic [6:0] a, input logic [7:0] code, output logic [1:0] ack);
        logic [8:0] r;
        u_mst.start_cond();
        u_mst.byte_io({a, 1'b0}, 1'b1, r);
        ack[1] = ~r[0];
        u_mst.byte_io(code, 1'b1, r);
        ack[0] = ~r[0];
        u_mst.stop_cond();
    endtask

    // Two acked bytes, checksum nacked
    task automatic rd(input logic [6:0] a, output logic [23:0] d);
        logic [8:0] r;
        u_mst.start_cond();
        u_mst.byte_io({a, 1'b1}, 1'b1, r);
        check(r[0], 1'b0);
        for (int i = 2; i >= 0; i--) begin
            u_mst.byte_io(8'hff, (i == 0), r);
            d[i * 8 +: 8] = r[8:1];
        end
        u_mst.stop_cond();
    endtask

    task automatic strobe(input logic [6:0] a, input logic perm);
        alt_addr_i = a;
        tmp_alt_wr_i = ~perm;
        perm_alt_wr_i = perm;
        @(posedge clk_i);
        #10;
        tmp_alt_wr_i = 1'b0;
        perm_alt_wr_i = 1'b0;
        @(posedge clk_i);
        #10;
    endtask

    task automatic t_convert();
        logic [1:0] ack;
        logic [23:0] d;
        int s0;
        int b0;
        s0 = starts;
        b0 = busy_cyc;
        adc_data_i = 16'h683a;
        cmd(`TSI_DEF_ADDR, `TSI_CMD_CONVERT, ack);
        u_mst.clk_flush();
        for (int i = 0; i < 1000 && conv_busy_o !== 1'b0; i++) @(posedge clk_i);
        #10;
        adc_data_i = 16'h1234;
        check({ack, 8'(starts - s0)}, {2'b11, 8'h01});
        check(24'(busy_cyc - b0), 24'(CONV));
        rd(`TSI_DEF_ADDR, d);
        check(d, {16'h683a, crc8(16'h683a)});
        cmd(`TSI_DEF_ADDR, `TSI_CMD_SERIAL, ack);
        rd(`TSI_DEF_ADDR, d);
        check(d, {SERIAL, crc8(SERIAL)});
        cmd(`TSI_DEF_ADDR, `TSI_CMD_READ, ack);
        rd(`TSI_DEF_ADDR, d);
        check(d, {16'h683a, crc8(16'h683a)});
    endtask

    task automatic t_addr_abort();
        logic [1:0] ack;
        logic [23:0] d;
        cmd(7'h41, 8'h55, ack);
        check(ack, 2'b00);
        strobe(7'h22, 1'b0);
        cmd(7'h22, 8'h55, ack);
        check(ack, 2'b11);
        cmd(`TSI_DEF_ADDR, `TSI_CMD_CONVERT, ack);
        check(conv_busy_o, 1'b1);
        cmd(`TSI_DEF_ADDR, `TSI_CMD_RESET, ack);
        check(conv_busy_o, 1'b0);
        cmd(7'h22, 8'h55, ack);
        check(ack, 2'b00);
        cmd(`TSI_DEF_ADDR, `TSI_CMD_READ, ack);
        rd(`TSI_DEF_ADDR, d);
        check(d, 24'h000000);
    endtask

    task automatic t_perm();
        logic [1:0] ack;
        check(mem_crc_ok_o, 1'b1);
        strobe(7'h33, 1'b1);
        check(mem_crc_ok_o, 1'b0);
        strobe(7'h34, 1'b1);
        cmd(7'h34, 8'h55, ack);
        check(ack, 2'b00);
        cmd(7'h33, 8'h55, ack);
        check(ack, 2'b11);
        cmd(`TSI_DEF_ADDR, 8'h55, ack);
        check(ack, 2'b11);
    endtask

    // Power restart: temporary address lost, production address taken
    task automatic t_restart();
        logic [1:0] ack;
        strobe(7'h25, 1'b0);
        cmd(7'h25, 8'h55, ack);
        check(ack, 2'b11);
        nvm_alt_addr = 7'h2b;
        nvm_alt_vld = 1'b1;
        sys_rst_i = 1'b1;
        repeat (2) @(posedge clk_i);
        #10;
        sys_rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #10;
        check({sda_oe_n_o, conv_busy_o, mem_crc_ok_o}, 3'b101);
        cmd(7'h25, 8'h55, ack);
        check(ack, 2'b00);
        cmd(7'h2b, 8'h55, ack);
        check(ack, 2'b11);
    endtask

    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        tmp_alt_wr_i = 1'b0;
        perm_alt_wr_i = 1'b0;
        adc_data_i = 16'h0000;
        alt_addr_i = 7'h00;
        nvm_alt_addr = 7'h00;
        nvm_alt_vld = 1'b0;
        repeat (8) @(posedge clk_i);
        #10;
        sys_rst_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #10;
        check({sda_oe_n_o, conv_busy_o}, 2'b10);
        t_convert();
        t_addr_abort();
        t_perm();
        t_restart();
        final_report();
    end
endmodule
